// [rtl/tone_sig_pkg.sv]
// constants, field layouts and carrier types of the tone signaling command registers
// Notes on behaviour
// - first byte of each bus transaction is the command; later bytes are data or reply
// - command 30h takes one data byte into the write-only control register
// - command 31h returns one reply byte with the status register
// - command 32h returns two reply bytes with the measured receive frequency word
// - command 33h takes one data byte as the no-tone timer period
// - command 34h takes two data bytes as the tone generator 1 word
// - command 35h takes two data bytes as the tone generator 2 word
// - command 36h takes one data byte as the general timer period
// - control bit 7 closes the audio switch when one
// - control bit 6 enables timer interrupt, bit 5 the decoder interrupts
// - control bit 4 closes the summing switch when one
// - control bits 3:2 pick high, mid or extended band; 11 is stored unchecked if sent
// - general reset command 01h clears the general timer period to zero
// - status bit 2 sets on timer expiry; read, new period or reset clear it
// - status bit 1 sets on no-tone expiry; read, new period or reset clear it
// - status bit 0 sets on measurement done; only read or reset clear it
// - status bits set whatever the interrupt enables say
// - interrupt request asserts while an enabled status condition is set
// - each tone generator word is 16 bits sent most significant bit first
// - generator 1 divisor is word bits 12:0; zero means powersave
// - generator 1 word bit 13 one holds the tone at bias, zero enables it
// - status bit 3 shows the level of the general purpose logic input
// - tone frequency is clock divided by four times the divisor
// - bus has serial clock, command data, reply data, select and interrupt lines
package tone_sig_pkg;
    localparam logic [7:0] CMD_GENERAL_RESET = 8'h01;
    localparam logic [7:0] CMD_CONTROL_CONFIG = 8'h30;
    localparam logic [7:0] CMD_EVENT_STATUS = 8'h31;
    localparam logic [7:0] CMD_RX_TONE_FREQUENCY = 8'h32;
    localparam logic [7:0] CMD_SILENCE_TIMER_PERIOD = 8'h33;
    localparam logic [7:0] CMD_TONE_GEN_ONE_WORD = 8'h34;
    localparam logic [7:0] CMD_TONE_GEN_TWO_WORD = 8'h35;
    localparam logic [7:0] CMD_GENERAL_TIMER_PERIOD = 8'h36;
    localparam logic [1:0] BYTES_NONE = 2'h0;
    localparam logic [1:0] BYTES_ONE = 2'h1;
    localparam logic [1:0] BYTES_TWO = 2'h2;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0] BAND_HIGH = 2'h0;
    localparam logic [1:0] BAND_MID = 2'h1;
    localparam logic [1:0] BAND_EXTENDED = 2'h2;
    localparam logic [3:0] STATUS_ZERO_BITS = 4'h0;
    localparam int TONE_CLOCKS_PER_STEP = 4;
    localparam int TONE_HALF_STEPS = 2;

    // control register layout, bit 7 first
    typedef struct packed {
        logic audio_switch;
        logic timer_irq_en;
        logic decoder_irq_en;
        logic sum_switch;
        logic [1:0] band;
        logic [1:0] spare;
    } control_s;

    // status register layout, bit 7 first
    typedef struct packed {
        logic [3:0] zero;
        logic logic_input;
        logic timer_expired;
        logic silence_expired;
        logic measure_done;
    } status_s;

    // tone generator 1 word layout, bit 15 first
    typedef struct packed {
        logic [1:0] spare;
        logic mute;
        logic [12:0] divisor;
    } tone_one_s;

    // link transaction phase
    typedef enum logic [2:0] {
        PH_CMD = 3'b001,
        PH_DATA = 3'b010,
        PH_IDLE = 3'b100
    } link_phase_e;
endpackage

// [rtl/tone_signaling_command_regs.sv]
// serial command decoder and register bank of the tone signaling processor
`timescale 1ns/1ps
`default_nettype none
module tone_signaling_command_regs #(
    parameter int DIV_W = 13
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic cmd_data_i,
    output logic reply_data_o,
    output logic irq_n_o,
    input wire logic logic_input_i,
    input wire logic timer_expired_i,
    input wire logic silence_expired_i,
    input wire logic measure_done_i,
    input wire logic [15:0] rx_freq_i,
    output logic audio_switch_o,
    output logic sum_switch_o,
    output logic [1:0] band_o,
    output logic [7:0] silence_period_o,
    output logic silence_load_o,
    output logic [7:0] timer_period_o,
    output logic timer_load_o,
    output logic general_reset_o,
    output logic [15:0] tone_two_word_o,
    output logic tone_one_wave_o,
    output logic tone_one_bias_o,
    output logic tone_one_powersave_o
);
    // ---------------- link domain, clocked by the host serial clock ----------------
    logic link_clr;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [1:0] left_q, left_d;
    tone_sig_pkg::link_phase_e phase_q, phase_d;
    logic [7:0] cmd_q, cmd_d;
    logic [15:0] data_q, data_d;
    logic wr_tog_q, wr_tog_d;
    logic rd_tog_q, rd_tog_d;
    logic [15:0] rsh_q, rsh_d;
    logic loaded_q, loaded_d;
    // snapshots read by the link; frozen while select is low
    tone_sig_pkg::status_s snap_status_q, snap_status_d;
    logic [15:0] snap_freq_q, snap_freq_d;

    // data bytes that follow a write command
    function automatic logic [1:0] write_bytes(input logic [7:0] cmd);
        case (cmd)
            tone_sig_pkg::CMD_CONTROL_CONFIG,
            tone_sig_pkg::CMD_SILENCE_TIMER_PERIOD,
            tone_sig_pkg::CMD_GENERAL_TIMER_PERIOD: write_bytes = tone_sig_pkg::BYTES_ONE;
            tone_sig_pkg::CMD_TONE_GEN_ONE_WORD,
            tone_sig_pkg::CMD_TONE_GEN_TWO_WORD: write_bytes = tone_sig_pkg::BYTES_TWO;
            default: write_bytes = tone_sig_pkg::BYTES_NONE;
        endcase
    endfunction

    // a high select ends the frame, so framing state clears without a clock
    assign link_clr = rst_i | cs_n_i;

    // shift in command data on the rising serial clock, frame into bytes
    always_comb begin
        sh_d = {sh_q[6:0], cmd_data_i};
        bit_d = bit_q + 3'h1;
        left_d = left_q;
        phase_d = phase_q;
        cmd_d = cmd_q;
        data_d = data_q;
        wr_tog_d = wr_tog_q;
        rd_tog_d = rd_tog_q;
        if (bit_q == tone_sig_pkg::LAST_BIT) begin
            unique case (phase_q)
                tone_sig_pkg::PH_CMD: begin
                    cmd_d = sh_d;
                    left_d = write_bytes(sh_d);
                    phase_d = tone_sig_pkg::PH_IDLE;
                    if (sh_d == tone_sig_pkg::CMD_GENERAL_RESET) begin
                        wr_tog_d = ~wr_tog_q;
                    end else if (sh_d == tone_sig_pkg::CMD_EVENT_STATUS) begin
                        rd_tog_d = ~rd_tog_q;
                    end else if (write_bytes(sh_d) != tone_sig_pkg::BYTES_NONE) begin
                        phase_d = tone_sig_pkg::PH_DATA;
                    end
                end
                tone_sig_pkg::PH_DATA: begin
                    data_d = {data_q[7:0], sh_d};
                    left_d = left_q - 2'h1;
                    if (left_q == tone_sig_pkg::BYTES_ONE) begin
                        wr_tog_d = ~wr_tog_q;
                        phase_d = tone_sig_pkg::PH_IDLE;
                    end
                end
                tone_sig_pkg::PH_IDLE: begin
                    phase_d = tone_sig_pkg::PH_IDLE; // surplus bytes are ignored
                end
            endcase
        end
    end

    // framing registers, cleared whenever select is high
    always_ff @(posedge sclk_i or posedge link_clr) begin
        if (link_clr) begin
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            left_q <= tone_sig_pkg::BYTES_NONE;
            phase_q <= tone_sig_pkg::PH_CMD;
        end else begin
            bit_q <= bit_d;
            sh_q <= sh_d;
            left_q <= left_d;
            phase_q <= phase_d;
        end
    end

    // command, data and event toggles survive the end of the frame
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_q <= 8'h00;
            data_q <= tone_sig_pkg::WORD_RESET;
            wr_tog_q <= 1'b0;
            rd_tog_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            data_q <= data_d;
            wr_tog_q <= wr_tog_d;
            rd_tog_q <= rd_tog_d;
        end
    end

    // reply shifter, loaded on the falling edge after the command byte
    always_comb begin
        rsh_d = {rsh_q[14:0], 1'b0};
        loaded_d = loaded_q;
        if (!loaded_q && phase_q != tone_sig_pkg::PH_CMD) begin
            loaded_d = 1'b1;
            if (cmd_q == tone_sig_pkg::CMD_EVENT_STATUS) begin
                rsh_d = {snap_status_q, 8'h00};
            end else if (cmd_q == tone_sig_pkg::CMD_RX_TONE_FREQUENCY) begin
                rsh_d = snap_freq_q;
            end else begin
                rsh_d = tone_sig_pkg::WORD_RESET;
            end
        end
    end

    // reply changes on the falling edge so the host samples it on the rising one
    always_ff @(negedge sclk_i or posedge link_clr) begin
        if (link_clr) begin
            rsh_q <= tone_sig_pkg::WORD_RESET;
            loaded_q <= 1'b0;
        end else begin
            rsh_q <= rsh_d;
            loaded_q <= loaded_d;
        end
    end

    assign reply_data_o = rsh_q[15];

    // ---------------- core domain ----------------
    logic [2:0] wr_sync_q;
    logic [2:0] rd_sync_q;
    logic [1:0] cs_sync_q;
    logic [1:0] lin_sync_q;
    logic wr_evt, rd_evt;
    tone_sig_pkg::control_s ctrl_q, ctrl_d;
    tone_sig_pkg::status_s status_q, status_d;
    logic [7:0] silence_q, silence_d;
    logic [7:0] timer_q, timer_d;
    tone_sig_pkg::tone_one_s tone1_q, tone1_d;
    logic [15:0] tone2_q, tone2_d;
    logic silence_load_q, silence_load_d;
    logic timer_load_q, timer_load_d;
    logic gen_reset_q, gen_reset_d;
    logic irq_n_q, irq_n_d;

    // toggles and pin levels pass two flops; the third flop gives the edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_sync_q <= 3'h0;
            rd_sync_q <= 3'h0;
            cs_sync_q <= 2'h3;
            lin_sync_q <= 2'h0;
        end else begin
            wr_sync_q <= {wr_sync_q[1:0], wr_tog_q};
            rd_sync_q <= {rd_sync_q[1:0], rd_tog_q};
            cs_sync_q <= {cs_sync_q[0], cs_n_i};
            lin_sync_q <= {lin_sync_q[0], logic_input_i};
        end
    end

    assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
    assign rd_evt = rd_sync_q[2] ^ rd_sync_q[1];

    // register writes, event flags and interrupt request
    always_comb begin
        ctrl_d = ctrl_q;
        silence_d = silence_q;
        timer_d = timer_q;
        tone1_d = tone1_q;
        tone2_d = tone2_q;
        silence_load_d = 1'b0;
        timer_load_d = 1'b0;
        gen_reset_d = 1'b0;
        status_d = status_q;
        // a read clears only the bits the host actually saw
        if (rd_evt) begin
            status_d.timer_expired = status_q.timer_expired & ~snap_status_q.timer_expired;
            status_d.silence_expired = status_q.silence_expired
                & ~snap_status_q.silence_expired;
            status_d.measure_done = status_q.measure_done
                & ~snap_status_q.measure_done;
        end
        if (wr_evt) begin
            case (cmd_q)
                tone_sig_pkg::CMD_GENERAL_RESET: begin
                    timer_d = tone_sig_pkg::PERIOD_RESET;
                    gen_reset_d = 1'b1;
                    status_d.timer_expired = 1'b0;
                    status_d.silence_expired = 1'b0;
                    status_d.measure_done = 1'b0;
                end
                tone_sig_pkg::CMD_CONTROL_CONFIG: ctrl_d = data_q[7:0];
                tone_sig_pkg::CMD_SILENCE_TIMER_PERIOD: begin
                    silence_d = data_q[7:0];
                    silence_load_d = 1'b1;
                    status_d.silence_expired = 1'b0;
                end
                tone_sig_pkg::CMD_TONE_GEN_ONE_WORD: tone1_d = data_q;
                tone_sig_pkg::CMD_TONE_GEN_TWO_WORD: tone2_d = data_q;
                tone_sig_pkg::CMD_GENERAL_TIMER_PERIOD: begin
                    timer_d = data_q[7:0];
                    timer_load_d = 1'b1;
                    status_d.timer_expired = 1'b0;
                end
                default: ;
            endcase
        end
        // events set regardless of enables, and win over any clear
        if (timer_expired_i) begin
            status_d.timer_expired = 1'b1;
        end
        if (silence_expired_i) begin
            status_d.silence_expired = 1'b1;
        end
        if (measure_done_i) begin
            status_d.measure_done = 1'b1;
        end
        status_d.zero = tone_sig_pkg::STATUS_ZERO_BITS;
        status_d.logic_input = lin_sync_q[1];
        // interrupt request, active low
        irq_n_d = ~((ctrl_q.timer_irq_en & status_q.timer_expired)
            | (ctrl_q.decoder_irq_en
            & (status_q.silence_expired | status_q.measure_done)));
        // snapshots follow live state only while the link is idle
        snap_status_d = snap_status_q;
        snap_freq_d = snap_freq_q;
        if (cs_sync_q[1]) begin
            snap_status_d = status_q;
            snap_freq_d = rx_freq_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= tone_sig_pkg::CONTROL_RESET;
            status_q <= '0;
            silence_q <= tone_sig_pkg::PERIOD_RESET;
            timer_q <= tone_sig_pkg::PERIOD_RESET;
            tone1_q <= tone_sig_pkg::WORD_RESET;
            tone2_q <= tone_sig_pkg::WORD_RESET;
            silence_load_q <= 1'b0;
            timer_load_q <= 1'b0;
            gen_reset_q <= 1'b0;
            irq_n_q <= 1'b1;
            snap_status_q <= '0;
            snap_freq_q <= tone_sig_pkg::WORD_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            status_q <= status_d;
            silence_q <= silence_d;
            timer_q <= timer_d;
            tone1_q <= tone1_d;
            tone2_q <= tone2_d;
            silence_load_q <= silence_load_d;
            timer_load_q <= timer_load_d;
            gen_reset_q <= gen_reset_d;
            irq_n_q <= irq_n_d;
            snap_status_q <= snap_status_d;
            snap_freq_q <= snap_freq_d;
        end
    end

    // ---------------- tone generator 1 ----------------
    localparam int HALF_W = DIV_W + 2;
    logic [HALF_W-1:0] tcnt_q, tcnt_d;
    logic [HALF_W-1:0] half_period;
    logic wave_q, wave_d;
    logic bias_q, bias_d;
    logic psave_q, psave_d;

    // half period is twice the divisor, full period four times it
    assign half_period = HALF_W'(tone1_q.divisor)
        * HALF_W'(tone_sig_pkg::TONE_CLOCKS_PER_STEP / tone_sig_pkg::TONE_HALF_STEPS);

    always_comb begin
        tcnt_d = tcnt_q + {{(HALF_W-1){1'b0}}, 1'b1};
        wave_d = wave_q;
        psave_d = (tone1_q.divisor == '0);
        bias_d = tone1_q.mute;
        if (psave_d) begin
            tcnt_d = '0;
            wave_d = 1'b0;
        end else if (tcnt_q + {{(HALF_W-1){1'b0}}, 1'b1} >= half_period) begin
            tcnt_d = '0;
            wave_d = ~wave_q;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tcnt_q <= '0;
            wave_q <= 1'b0;
            bias_q <= 1'b0;
            psave_q <= 1'b1;
        end else begin
            tcnt_q <= tcnt_d;
            wave_q <= wave_d;
            bias_q <= bias_d;
            psave_q <= psave_d;
        end
    end

    // outputs, all straight from registers
    assign irq_n_o = irq_n_q;
    assign audio_switch_o = ctrl_q.audio_switch;
    assign sum_switch_o = ctrl_q.sum_switch;
    assign band_o = ctrl_q.band;
    assign silence_period_o = silence_q;
    assign silence_load_o = silence_load_q;
    assign timer_period_o = timer_q;
    assign timer_load_o = timer_load_q;
    assign general_reset_o = gen_reset_q;
    assign tone_two_word_o = tone2_q;
    assign tone_one_wave_o = wave_q;
    assign tone_one_bias_o = bias_q;
    assign tone_one_powersave_o = psave_q;
endmodule
`default_nettype wire

// [test/tone_sig_properties.sv]
// assertion checker for the tone signaling command registers
`timescale 1ns/1ps
`default_nettype none
module tone_sig_properties #(
    parameter int DIV_W = 13
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic timer_expired_i,
    input wire logic silence_expired_i,
    input wire logic measure_done_i,
    input wire logic reply_data_o,
    input wire logic irq_n_o,
    input wire logic [1:0] band_o,
    input wire logic [7:0] timer_period_o,
    input wire logic timer_load_o,
    input wire logic silence_load_o,
    input wire logic general_reset_o,
    input wire logic tone_one_wave_o,
    input wire logic tone_one_powersave_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // an event, or an open frame whose control write may enable a pending bit
    logic any_ev;
    assign any_ev = timer_expired_i | silence_expired_i | measure_done_i | ~cs_n_i;
    irq_fall_a: assert property ($fell(irq_n_o) |-> $past(any_ev, 2))
        else $error("irq fell with no event");
    irq_rise_a: assert property ($rose(irq_n_o) |-> !$past(cs_n_i, 2))
        else $error("irq released outside a frame");
    timer_load_a: assert property (
        timer_load_o |-> !$past(cs_n_i, 2) ##1 !timer_load_o)
        else $error("timer load pulse wrong");
    silence_load_a: assert property (
        silence_load_o |-> !$past(cs_n_i, 2) ##1 !silence_load_o)
        else $error("silence load pulse wrong");
    greset_pulse_a: assert property (general_reset_o |=> !general_reset_o)
        else $error("general reset pulse too long");
    greset_zero_a: assert property (general_reset_o |-> timer_period_o == 8'h00)
        else $error("timer period not cleared");
    reply_idle_a: assert property (cs_n_i [*4] |-> !reply_data_o)
        else $error("reply line busy while deselected");
    band_frame_a: assert property ($changed(band_o) |-> !$past(cs_n_i, 2))
        else $error("band changed outside a frame");
    wave_quiet_a: assert property (
        tone_one_powersave_o [*3] |-> $stable(tone_one_wave_o))
        else $error("tone toggles in powersave");
    wave_step_a: assert property (
        $changed(tone_one_wave_o) && cs_n_i |=> $stable(tone_one_wave_o))
        else $error("tone half period too short");
    // main scenarios reached
    cover property ($fell(irq_n_o));
    cover property (general_reset_o);
    cover property (timer_load_o);
    cover property ($rose(tone_one_wave_o));
endmodule
bind tone_signaling_command_regs tone_sig_properties #(.DIV_W(DIV_W)) i_tone_sig_properties (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .timer_expired_i(timer_expired_i),
    .silence_expired_i(silence_expired_i), .measure_done_i(measure_done_i),
    .reply_data_o(reply_data_o), .irq_n_o(irq_n_o), .band_o(band_o),
    .timer_period_o(timer_period_o), .timer_load_o(timer_load_o),
    .silence_load_o(silence_load_o), .general_reset_o(general_reset_o),
    .tone_one_wave_o(tone_one_wave_o), .tone_one_powersave_o(tone_one_powersave_o)
);
`default_nettype wire

// [test/tone_host_model.sv]
// host controller model driving the serial control bus
`timescale 1ns/1ps
`default_nettype none
module tone_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic cmd_data_o,
    input wire logic reply_data_i
);
    // bus idle: clock stopped low, deselected
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        cmd_data_o = 1'b1;
    end
    // one frame: command byte, then nb bytes written or read back
    task automatic frame(input logic [7:0] cmd, input int nb, input logic [15:0] wr,
                         output logic [15:0] rd);
        logic [23:0] v;
        v = {cmd, wr << (16 - 8 * nb)};
        rd = 16'h0000;
        #7 cs_n_o = 1'b0;
        #50;
        for (int i = 0; i < 8 + 8 * nb; i++) begin
            cmd_data_o = v[23 - i];
            #40 sclk_o = 1'b1;
            if (i >= 8) rd = {rd[14:0], reply_data_i};
            #40 sclk_o = 1'b0;
        end
        cmd_data_o = ~cmd_data_o; // released line shows the inverse
        #50 cs_n_o = 1'b1;
        #60;
    endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the tone signaling command registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lin = 1'b0;
    logic t_ev = 1'b0;
    logic s_ev = 1'b0;
    logic m_ev = 1'b0;
    logic [15:0] freq = 16'h0000;
    logic sclk, cs_n, cmd_d, reply, irq_n, aud, sum, sload, tload, greset, wave, bias, psave;
    logic [1:0] band;
    logic [7:0] sper, tper;
    logic [15:0] t2w, rd;
    logic [31:0] seed = 32'h3AAC;
    int err_count = 0;
    int tests_run = 0;
    logic [3:0] sload_cnt = 4'h0;
    logic [3:0] tload_cnt = 4'h0;
    logic [3:0] greset_cnt = 4'h0;
    // core clock
    always #2.5 clk = ~clk;
    // one-cycle load and reset pulses, counted outside reset
    always @(posedge clk) begin
        if (!rst) begin
            sload_cnt <= sload_cnt + {3'h0, sload};
            tload_cnt <= tload_cnt + {3'h0, tload};
            greset_cnt <= greset_cnt + {3'h0, greset};
        end
    end
    tone_signaling_command_regs i_tone_signaling_command_regs (
        .clk_i(clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .cmd_data_i(cmd_d),
        .reply_data_o(reply), .irq_n_o(irq_n), .logic_input_i(lin), .timer_expired_i(t_ev),
        .silence_expired_i(s_ev), .measure_done_i(m_ev), .rx_freq_i(freq),
        .audio_switch_o(aud), .sum_switch_o(sum), .band_o(band), .silence_period_o(sper),
        .silence_load_o(sload), .timer_period_o(tper), .timer_load_o(tload),
        .general_reset_o(greset), .tone_two_word_o(t2w), .tone_one_wave_o(wave),
        .tone_one_bias_o(bias), .tone_one_powersave_o(psave)
    );
    tone_host_model i_tone_host_model (
        .sclk_o(sclk), .cs_n_o(cs_n), .cmd_data_o(cmd_d), .reply_data_i(reply)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_status(input logic li, input logic [2:0] ev);
        return {4'h0, li, ev};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic xfer(input logic [7:0] c, input int nb, input logic [15:0] w);
        i_tone_host_model.frame(c, nb, w, rd);
        repeat (4) @(posedge clk);
    endtask
    // one-cycle event pulses: timer, silence, measure
    task automatic pulse(input logic [2:0] ev);
        @(posedge clk);
        {t_ev, s_ev, m_ev} <= ev;
        @(posedge clk);
        {t_ev, s_ev, m_ev} <= 3'b000;
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_wave(input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wave !== lvl && n < 200);
        if (wave !== lvl) begin
            err_count++;
            $display("unexpected at %0t: tone output stuck", $time);
            test_done();
        end
    endtask
    // hang guard
    initial begin
        #500000;
        err_count++;
        $display("unexpected at %0t: run timed out", $time);
        test_done();
    end
    // main sequence
    initial begin
        logic [7:0] c;
        logic [15:0] w;
        int a;
        int b;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk({12'h000, irq_n, aud, psave, reply}, 16'h000A, "reset");
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            c = {seed[7], 2'b00, seed[4], 2'(k % 3), 2'b00};
            xfer(8'h30, 1, {8'h00, c});
            chk({12'h000, aud, sum, band}, {12'h000, c[7], c[4], c[3:2]}, "ctrl");
        end
        xfer(8'h3F, 2, 16'hFFFF);
        chk({12'h000, aud, sum, band}, {12'h000, c[7], c[4], c[3:2]}, "unknown");
        lin <= 1'b1;
        pulse(3'b111);
        xfer(8'h31, 1, 16'h0000);
        chk(rd, {8'h00, exp_status(1'b1, 3'b111)}, "status");
        xfer(8'h31, 1, 16'h0000);
        chk(rd, {8'h00, exp_status(1'b1, 3'b000)}, "cleared");
        lin <= 1'b0;
        xfer(8'h30, 1, 16'h0040);
        pulse(3'b011);
        chk({15'h0000, irq_n}, 16'h0001, "masked");
        xfer(8'h31, 1, 16'h0000);
        pulse(3'b100);
        chk({15'h0000, irq_n}, 16'h0000, "timer irq");
        xfer(8'h31, 1, 16'h0000);
        chk({15'h0000, irq_n}, 16'h0001, "irq clear");
        xfer(8'h30, 1, 16'h0020);
        pulse(3'b011);
        seed = lfsr(seed);
        xfer(8'h33, 1, {8'h00, seed[7:0]});
        chk({8'h00, sper}, {8'h00, seed[7:0]}, "silence");
        chk({15'h0000, irq_n}, 16'h0000, "decoder irq");
        pulse(3'b100);
        xfer(8'h36, 1, 16'h005A);
        chk({8'h00, tper}, 16'h005A, "timer");
        xfer(8'h36, 0, 16'h0000);
        chk({8'h00, tper}, 16'h005A, "cut frame");
        xfer(8'h31, 1, 16'h0000);
        chk(rd, {8'h00, exp_status(1'b0, 3'b001)}, "partial");
        chk({15'h0000, irq_n}, 16'h0001, "irq idle");
        seed = lfsr(seed);
        freq <= seed[15:0];
        xfer(8'h32, 2, 16'h0000);
        chk(rd, freq, "frequency");
        seed = lfsr(seed);
        w = {3'b000, 13'(seed[2:0]) + 13'h0002};
        xfer(8'h34, 2, w);
        chk({14'h0000, bias, psave}, 16'h0000, "tone on");
        wait_wave(1'b0, a);
        wait_wave(1'b1, a);
        wait_wave(1'b0, a);
        wait_wave(1'b1, b);
        chk(16'(a + b), {1'b0, w[12:0], 2'b00}, "tone period");
        xfer(8'h34, 2, 16'h2000);
        chk({14'h0000, bias, psave}, 16'h0003, "tone off");
        seed = lfsr(seed);
        xfer(8'h35, 2, seed[15:0]);
        chk(t2w, seed[15:0], "tone two");
        pulse(3'b111);
        xfer(8'h01, 0, 16'h0000);
        chk({8'h00, tper}, 16'h0000, "reset period");
        xfer(8'h31, 1, 16'h0000);
        chk(rd, 16'h0000, "reset status");
        chk({4'h0, sload_cnt, tload_cnt, greset_cnt}, 16'h0111, "pulses");
        test_done();
    end
endmodule
`default_nettype wire
